// ---- svp_defs.svh ----
`ifndef SVP_DEFS_SVH
`define SVP_DEFS_SVH

// timing
`define SVP_CLK_HZ 20000000
`define SVP_MS_PER_S 1000
`define SVP_UPDATE_MS 5
`define SVP_STALE_UPDATES 2

// register byte addresses
`define SVP_ADDR_CTRL 8'h00
`define SVP_ADDR_USET 8'h04
`define SVP_ADDR_UBLK 8'h08
`define SVP_ADDR_DELAY 8'h0c
`define SVP_ADDR_STATUS 8'h10
`define SVP_ADDR_IRQ_STAT 8'h14
`define SVP_ADDR_IRQ_MASK 8'h18
`define SVP_ADDR_MAG 8'h1c
`define SVP_ADDR_CH4 8'h20
`define SVP_ADDR_CNT_START 8'h24
`define SVP_ADDR_CNT_TRIP 8'h28
`define SVP_ADDR_CNT_BLOCKED 8'h2c

// control register fields
`define SVP_CTRL_NEG_BIT 0
`define SVP_CTRL_UNDER_BIT 1
`define SVP_CTRL_FORCE_EN_BIT 2
`define SVP_CTRL_FORCE_LSB 3
`define SVP_CTRL_FORCE_MSB 4

// status register fields
`define SVP_ST_PICKUP 0
`define SVP_ST_START 1
`define SVP_ST_TRIP 2
`define SVP_ST_BLOCKED 3
`define SVP_ST_UVBLK 4
`define SVP_ST_STALE 5

// interrupt status and mask fields
`define SVP_IRQ_START 0
`define SVP_IRQ_TRIP 1
`define SVP_IRQ_BLOCKED 2
`define SVP_IRQ_STALE 3

// reset values, levels in 0.01 % of nominal
`define SVP_USET_RESET 14'h2904
`define SVP_UBLK_RESET 14'h01f4
`define SVP_DELAY_MS_RESET 40

// level arithmetic
`define SVP_PCT_FULL 10000
`define SVP_PCT 100
`define SVP_REL_OVER_PCT 97
`define SVP_REL_UNDER_PCT 103
`define SVP_LINE_RATIO2 3

// q15 rotation constants
`define SVP_UNITY 34'sh8000
`define SVP_ROT_HALF 34'sh4000
`define SVP_ROT_SIN 34'sh6eda
`define SVP_THIRD 48'sh2aab

`endif

// ---- svp_pkg.sv ----
`default_nettype none
package svp_pkg;

   typedef struct packed {
      logic signed [15:0] re;
      logic signed [15:0] im;
   } svp_phasor_type;

   typedef svp_phasor_type [3:0] svp_chan_set_type;

   typedef struct packed {
      logic signed [33:0] re;
      logic signed [33:0] im;
   } svp_wide_type;

   typedef enum logic [1:0] {
      SVP_FORCE_NORMAL,
      SVP_FORCE_START,
      SVP_FORCE_TRIP,
      SVP_FORCE_BLOCKED
   } svp_force_type;

   typedef struct packed {
      logic start;
      logic trip;
      logic blocked;
   } svp_status_type;

   function automatic logic [36:0] svp_mag2(input logic signed [17:0] re,
                                            input logic signed [17:0] im);
      logic signed [35:0] pr;
      logic signed [35:0] pi;
      pr = re * re;
      pi = im * im;
      return {1'b0, pr} + {1'b0, pi};
   endfunction : svp_mag2

endpackage : svp_pkg
`default_nettype wire

// ---- svp_seq_calc.sv ----
`include "svp_defs.svh"
`default_nettype none
module svp_seq_calc (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // registered phasor set
   input wire logic load,
   input wire logic neg_sel,
   input wire svp_pkg::svp_chan_set_type chans,
   // squared sequence magnitude
   output logic valid,
   output logic [36:0] mag2
);
   import svp_pkg::*;

   typedef struct packed {
      logic valid;
      logic [36:0] mag2;
   } svp_calc_state_type;

   svp_calc_state_type state_r;
   svp_calc_state_type state_nxt;

   // rotate by 120 degrees, or by 240 when twice is set; scaled by 2^15
   function automatic svp_wide_type svp_rotate(input svp_phasor_type x,
                                               input logic twice);
      svp_wide_type w;
      logic signed [33:0] xr;
      logic signed [33:0] xi;
      xr = 34'(x.re);
      xi = 34'(x.im);
      if (!twice) begin
         w.re = -(xr * `SVP_ROT_HALF) - xi * `SVP_ROT_SIN;
         w.im = xr * `SVP_ROT_SIN - xi * `SVP_ROT_HALF;
      end else begin
         w.re = xi * `SVP_ROT_SIN - xr * `SVP_ROT_HALF;
         w.im = -(xr * `SVP_ROT_SIN) - xi * `SVP_ROT_HALF;
      end
      return w;
   endfunction : svp_rotate

   always_comb begin
      svp_wide_type r2;
      svp_wide_type r3;
      logic signed [33:0] t_re;
      logic signed [33:0] t_im;
      logic signed [47:0] d_re;
      logic signed [47:0] d_im;
      r2 = svp_rotate(chans[1], neg_sel);
      r3 = svp_rotate(chans[2], !neg_sel);
      t_re = 34'(chans[0].re) * `SVP_UNITY + r2.re + r3.re;
      t_im = 34'(chans[0].im) * `SVP_UNITY + r2.im + r3.im;
      // one third and the 2^15 scale removed together by the shift below
      d_re = 48'(t_re) * `SVP_THIRD;
      d_im = 48'(t_im) * `SVP_THIRD;
      state_nxt = state_r;
      state_nxt.valid = load;
      if (load) begin
         state_nxt.mag2 = svp_mag2($signed(d_re[47:30]), $signed(d_im[47:30]));
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign valid = state_r.valid;
   assign mag2 = state_r.mag2;

endmodule : svp_seq_calc
`default_nettype wire

// ---- svp_stage.sv ----
// Chosen here: the register offsets and the AHB-Lite register port.
`include "svp_defs.svh"
`default_nettype none
// Summary of operation
// - positive sequence from phases rotated 0, 120, 240
// - negative sequence from phases rotated 0, 240, 120
// - four channel phasors refreshed every 5 ms
// - selector picks positive or negative sequence
// - forcing sets normal, start, trip or blocked
// - direction selects overvoltage or undervoltage pick-up
// - pick-up level in 0.01 percent, default 105
// - pick-up when magnitude crosses level in direction
// - overvoltage releases below 97 percent of level
// - undervoltage releases above 103 percent of level
// - undervoltage block level, default 5 percent
// - setting changes take effect without restart
// - block holds until all line voltages recover
// - zero block level disables undervoltage blocking
// - external block during pick-up gives blocked and clears start
// - trip after delay, default 40 ms, zero instant
module svp_stage #(
   parameter logic [15:0] UN_COUNTS = 16'h4000,
   parameter int UPDATE_CYCLES = `SVP_UPDATE_MS * (`SVP_CLK_HZ / `SVP_MS_PER_S)
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // measurement front end
   input wire logic meas_valid,
   input wire svp_pkg::svp_chan_set_type meas_chans,
   // external block input, asynchronous
   input wire logic block_in,
   // stage outputs
   output logic start_o,
   output logic trip_o,
   output logic blocked_o,
   output logic irq
);
   import svp_pkg::*;

   localparam int STALE_CYCLES = `SVP_STALE_UPDATES * UPDATE_CYCLES;
   localparam logic [79:0] SCALE2 = 80'(`SVP_PCT_FULL * `SVP_PCT_FULL);
   localparam logic [79:0] PCT2 = 80'(`SVP_PCT * `SVP_PCT);
   localparam logic [79:0] REL_OVER2 =
      80'(`SVP_REL_OVER_PCT * `SVP_REL_OVER_PCT);
   localparam logic [79:0] REL_UNDER2 =
      80'(`SVP_REL_UNDER_PCT * `SVP_REL_UNDER_PCT);
   localparam logic [18:0] DELAY_RESET =
      19'(`SVP_DELAY_MS_RESET / `SVP_UPDATE_MS);

   if (UN_COUNTS == 16'h0000 || UPDATE_CYCLES < 2) begin : g_bad_param
      $error("svp_stage: unsupported parameter value");
   end

   typedef struct packed {
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] rdata;
      logic neg_sel;
      logic under;
      logic force_en;
      svp_force_type force_state;
      logic [13:0] uset;
      logic [13:0] ublk;
      logic [18:0] delay;
      logic [3:0] irq_stat;
      logic [3:0] irq_mask;
      logic [2:0][15:0] ev_cnt;
      logic blk_ff1;
      logic blk_ff2;
      svp_chan_set_type chans;
      logic load;
      logic lines_up;
      logic [36:0] mag;
      logic pickup;
      logic start;
      logic trip;
      logic blocked;
      logic uvblk;
      logic [18:0] op_cnt;
      logic [31:0] idle_cnt;
      logic stale;
      svp_status_type outs;
   } svp_state_type;

   svp_state_type state_r;
   svp_state_type state_nxt;
   logic seq_valid;
   logic [36:0] seq_mag2;

   function automatic logic [31:0] svp_read(input logic [7:0] a,
                                            input svp_state_type x);
      logic [31:0] d;
      d = 32'h0000_0000;
      case (a)
         `SVP_ADDR_CTRL: begin
            d[`SVP_CTRL_NEG_BIT] = x.neg_sel;
            d[`SVP_CTRL_UNDER_BIT] = x.under;
            d[`SVP_CTRL_FORCE_EN_BIT] = x.force_en;
            d[`SVP_CTRL_FORCE_MSB:`SVP_CTRL_FORCE_LSB] = x.force_state;
         end
         `SVP_ADDR_USET: d[13:0] = x.uset;
         `SVP_ADDR_UBLK: d[13:0] = x.ublk;
         `SVP_ADDR_DELAY: d[18:0] = x.delay;
         `SVP_ADDR_STATUS: begin
            d[`SVP_ST_PICKUP] = x.pickup;
            d[`SVP_ST_START] = x.outs.start;
            d[`SVP_ST_TRIP] = x.outs.trip;
            d[`SVP_ST_BLOCKED] = x.outs.blocked;
            d[`SVP_ST_UVBLK] = x.uvblk;
            d[`SVP_ST_STALE] = x.stale;
         end
         `SVP_ADDR_IRQ_STAT: d[3:0] = x.irq_stat;
         `SVP_ADDR_IRQ_MASK: d[3:0] = x.irq_mask;
         `SVP_ADDR_MAG: d = x.mag[36:5];
         `SVP_ADDR_CH4: d = {x.chans[3].re, x.chans[3].im};
         `SVP_ADDR_CNT_START: d[15:0] = x.ev_cnt[0];
         `SVP_ADDR_CNT_TRIP: d[15:0] = x.ev_cnt[1];
         `SVP_ADDR_CNT_BLOCKED: d[15:0] = x.ev_cnt[2];
         default: d = 32'h0000_0000;
      endcase
      return d;
   endfunction : svp_read

   svp_seq_calc u_seq_calc (
      .hclk(hclk),
      .hresetn(hresetn),
      .load(state_r.load),
      .neg_sel(state_r.neg_sel),
      .chans(state_r.chans),
      .valid(seq_valid),
      .mag2(seq_mag2)
   );

   always_comb begin
      logic addr_ok;
      logic [29:0] lvl;
      logic [29:0] blk_lvl;
      logic [79:0] m;
      logic [79:0] p;
      logic [79:0] b;
      logic pk;
      logic uv;
      logic ups;
      logic [18:0] cnt;
      logic [3:0] ev;
      logic signed [17:0] lr;
      logic signed [17:0] li;
      svp_state_type s;
      s = state_r;
      state_nxt = state_r;
      addr_ok = hsel && hready && htrans[1];
      lvl = 30'(state_r.uset) * 30'(UN_COUNTS);
      blk_lvl = 30'(state_r.ublk) * 30'(UN_COUNTS);
      p = 80'(lvl) * 80'(lvl);
      b = 80'(blk_lvl) * 80'(blk_lvl);
      m = 80'(seq_mag2) * SCALE2;
      pk = s.pickup;
      uv = s.uvblk;
      ups = 1'b1;
      cnt = s.op_cnt;
      ev = 4'h0;
      lr = 18'sh00000;
      li = 18'sh00000;

      // register writes land in the data phase; new settings other than forcing and
      // the irq mask are used at the next update while the stage state is kept
      if (s.wr_pend) begin
         case (s.wr_addr)
            `SVP_ADDR_CTRL: begin
               state_nxt.neg_sel = hwdata[`SVP_CTRL_NEG_BIT];
               state_nxt.under = hwdata[`SVP_CTRL_UNDER_BIT];
               state_nxt.force_en = hwdata[`SVP_CTRL_FORCE_EN_BIT];
               state_nxt.force_state = svp_force_type'(
                  hwdata[`SVP_CTRL_FORCE_MSB:`SVP_CTRL_FORCE_LSB]);
            end
            `SVP_ADDR_USET: state_nxt.uset = hwdata[13:0];
            `SVP_ADDR_UBLK: state_nxt.ublk = hwdata[13:0];
            `SVP_ADDR_DELAY: state_nxt.delay = hwdata[18:0];
            `SVP_ADDR_IRQ_STAT: state_nxt.irq_stat = s.irq_stat & ~hwdata[3:0];
            `SVP_ADDR_IRQ_MASK: state_nxt.irq_mask = hwdata[3:0];
            `SVP_ADDR_CNT_START: state_nxt.ev_cnt[0] = 16'h0000;
            `SVP_ADDR_CNT_TRIP: state_nxt.ev_cnt[1] = 16'h0000;
            `SVP_ADDR_CNT_BLOCKED: state_nxt.ev_cnt[2] = 16'h0000;
            default: ;
         endcase
      end
      state_nxt.wr_pend = addr_ok && hwrite;
      if (addr_ok) begin
         state_nxt.wr_addr = haddr[7:0];
      end

      // block input synchroniser, second stage is the only reader
      state_nxt.blk_ff1 = block_in;
      state_nxt.blk_ff2 = s.blk_ff1;

      // capture each phasor set before any comparison
      state_nxt.load = meas_valid;
      if (meas_valid) begin
         state_nxt.chans = meas_chans;
         state_nxt.idle_cnt = 32'h0000_0000;
         state_nxt.stale = 1'b0;
      end else if (s.idle_cnt < 32'(STALE_CYCLES)) begin
         state_nxt.idle_cnt = s.idle_cnt + 32'h0000_0001;
      end else begin
         state_nxt.stale = 1'b1;
      end

      // line voltages of the captured set against the level in line terms
      if (s.load) begin
         for (int i = 0; i < 3; i++) begin
            lr = 18'(s.chans[i].re) - 18'(s.chans[(i + 1) % 3].re);
            li = 18'(s.chans[i].im) - 18'(s.chans[(i + 1) % 3].im);
            ups = ups && (80'(svp_mag2(lr, li)) * SCALE2 >
                          80'(`SVP_LINE_RATIO2) * p);
         end
         state_nxt.lines_up = ups;
      end

      if (seq_valid) begin
         state_nxt.mag = seq_mag2;
         // squared compare avoids a square root in hardware
         if (!s.under) begin
            if (s.pickup) begin
               pk = !(m * PCT2 < REL_OVER2 * p);
            end else begin
               pk = m > p;
            end
         end else begin
            if (s.pickup) begin
               pk = !(m * PCT2 > REL_UNDER2 * p);
            end else begin
               pk = m < p;
            end
         end
         if (!s.under || s.ublk == 14'h0000) begin
            uv = 1'b0;
         end else if (m < b) begin
            uv = 1'b1;
         end else if (s.lines_up) begin
            uv = 1'b0;
         end
         state_nxt.pickup = pk;
         state_nxt.uvblk = uv;
         if (pk && s.blk_ff2) begin
            state_nxt.blocked = 1'b1;
            state_nxt.start = 1'b0;
            state_nxt.trip = 1'b0;
            state_nxt.op_cnt = 19'h00000;
         end else if (pk) begin
            if (s.start && s.op_cnt != 19'h7ffff) begin
               cnt = s.op_cnt + 19'h00001;
            end else if (!s.start) begin
               cnt = 19'h00000;
            end
            state_nxt.blocked = 1'b0;
            state_nxt.start = 1'b1;
            state_nxt.op_cnt = cnt;
            // a zero delay trips in the same update as start
            state_nxt.trip = !uv && (cnt >= s.delay);
         end else begin
            state_nxt.blocked = 1'b0;
            state_nxt.start = 1'b0;
            state_nxt.trip = 1'b0;
            state_nxt.op_cnt = 19'h00000;
         end
      end

      // forcing overrides the measured status only while enabled
      if (state_nxt.force_en) begin
         unique case (state_nxt.force_state)
            SVP_FORCE_NORMAL: state_nxt.outs = '{1'b0, 1'b0, 1'b0};
            SVP_FORCE_START: state_nxt.outs = '{1'b1, 1'b0, 1'b0};
            SVP_FORCE_TRIP: state_nxt.outs = '{1'b1, 1'b1, 1'b0};
            SVP_FORCE_BLOCKED: state_nxt.outs = '{1'b0, 1'b0, 1'b1};
         endcase
      end else begin
         state_nxt.outs = '{state_nxt.start, state_nxt.trip,
                            state_nxt.blocked};
      end

      // rising edges are events; a set in the clearing cycle wins
      ev[`SVP_IRQ_START] = state_nxt.outs.start && !s.outs.start;
      ev[`SVP_IRQ_TRIP] = state_nxt.outs.trip && !s.outs.trip;
      ev[`SVP_IRQ_BLOCKED] = state_nxt.outs.blocked && !s.outs.blocked;
      ev[`SVP_IRQ_STALE] = state_nxt.stale && !s.stale;
      state_nxt.irq_stat = state_nxt.irq_stat | ev;
      for (int i = 0; i < 3; i++) begin
         if (ev[i] && state_nxt.ev_cnt[i] != 16'hffff) begin
            state_nxt.ev_cnt[i] = state_nxt.ev_cnt[i] + 16'h0001;
         end
      end

      // read data taken from the post-write view so a read right after a
      // write sees the new value
      if (addr_ok && !hwrite) begin
         state_nxt.rdata = svp_read(haddr[7:0], state_nxt);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= '0;
         state_r.uset <= `SVP_USET_RESET;
         state_r.ublk <= `SVP_UBLK_RESET;
         state_r.delay <= DELAY_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign hrdata = state_r.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign start_o = state_r.outs.start;
   assign trip_o = state_r.outs.trip;
   assign blocked_o = state_r.outs.blocked;
   assign irq = |(state_r.irq_stat & state_r.irq_mask);

endmodule : svp_stage
`default_nettype wire

// ---- svp_stage_monitor.sv ----
`default_nettype none
module svp_stage_monitor (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // stage
   input wire logic meas_valid,
   input wire logic start_o,
   input wire logic trip_o,
   input wire logic blocked_o,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] quiet_r;
   logic [3:0] quiet_nxt;
   logic kick;
   // outputs may only move shortly after an update or a settings write
   assign kick = meas_valid | (hsel & hready & htrans[1] & hwrite);
   always_comb begin
      quiet_nxt = quiet_r;
      if (kick) begin
         quiet_nxt = 4'h0;
      end else if (quiet_r != 4'hf) begin
         quiet_nxt = quiet_r + 4'h1;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         quiet_r <= 4'hf;
      end else begin
         quiet_r <= quiet_nxt;
      end
   end
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   a_ready_high: assert property (hreadyout)
      else $error("hreadyout low");
   a_resp_okay: assert property (!hresp)
      else $error("hresp not okay");
   a_read_hold: assert property ($changed(hrdata) |->
      $past(hsel && hready && htrans[1] && !hwrite))
      else $error("hrdata moved without read");
   a_start_block_excl: assert property (!(start_o && blocked_o))
      else $error("start and blocked together");
   a_trip_needs_start: assert property (trip_o |-> start_o)
      else $error("trip without start");
   a_out_quiet: assert property ($changed({start_o, trip_o, blocked_o})
      |-> quiet_r <= 4'h6)
      else $error("outputs moved without update");
   a_trip_rise_time: assert property ($rose(trip_o)
      |-> $past(quiet_r) <= 4'h5)
      else $error("trip rose off an update");
   a_reset_clear: assert property ($rose(hresetn)
      |-> !start_o && !trip_o && !blocked_o && !irq)
      else $error("outputs not clear after reset");
endmodule : svp_stage_monitor
bind svp_stage svp_stage_monitor u_mon (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .meas_valid(meas_valid), .start_o(start_o), .trip_o(trip_o),
   .blocked_o(blocked_o), .irq(irq));
`default_nettype wire

// ---- svp_stage_tb.sv ----
`include "svp_defs.svh"
`default_nettype none
module svp_stage_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import svp_pkg::*;
   localparam logic [15:0] UN = 16'h4000;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic meas_valid = 1'b0;
   svp_chan_set_type meas_chans = '0;
   logic block_in = 1'b0;
   logic [31:0] hrdata, rd;
   logic hready, hresp, start_o, trip_o, blocked_o, irq;
   logic [2:0] ft [4] = '{3'b000, 3'b100, 3'b110, 3'b001};
   int bad_count = 0;
   int samples_checked = 0;

   always #25 hclk = ~hclk;

   // short update period so the stale supervision is reached in the run
   svp_stage #(.UN_COUNTS(UN), .UPDATE_CYCLES(20)) DUT (.hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hready), .hresp(hresp), .meas_valid(meas_valid),
      .meas_chans(meas_chans), .block_in(block_in), .start_o(start_o),
      .trip_o(trip_o), .blocked_o(blocked_o), .irq(irq));

   task end_of_test;
      $display("compared %0d, mismatched %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_of_test

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask : bus

   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task rdc(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rdc

   // balanced set at pct of nominal; neg swaps the phase rotation
   task upd(input int pct, input logic neg);
      real a, s, h;
      svp_chan_set_type c;
      a = pct * real'(UN) / 100.0;
      s = a * 0.8660254;
      h = a / 2.0;
      c[0] = {16'($rtoi(a)), 16'h0};
      c[1] = {16'($rtoi(-h)), 16'($rtoi(neg ? s : -s))};
      c[2] = {16'($rtoi(-h)), 16'($rtoi(neg ? -s : s))};
      c[3] = {16'(pct), 16'h5a5a};
      @(posedge hclk);
      meas_chans <= c;
      meas_valid <= 1'b1;
      @(posedge hclk);
      meas_valid <= 1'b0;
      repeat (4) @(posedge hclk);
   endtask : upd

   task outs(input logic [2:0] exp);
      chk({29'h0, start_o, trip_o, blocked_o}, {29'h0, exp});
   endtask : outs

   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      rdc(`SVP_ADDR_CTRL, 32'h0);
      rdc(`SVP_ADDR_USET, 32'h2904);
      rdc(`SVP_ADDR_UBLK, 32'h1f4);
      rdc(`SVP_ADDR_DELAY, 32'h8);
      rdc(`SVP_ADDR_IRQ_MASK, 32'h0);
      rdc(`SVP_ADDR_STATUS, 32'h0);
      rdc(8'h40, 32'h0);
      wr(`SVP_ADDR_DELAY, 32'h2);
      wr(`SVP_ADDR_IRQ_MASK, 32'h1);
      upd(100, 1'b0);
      outs(3'b000);
      upd(110, 1'b0);
      outs(3'b100);
      chk({31'h0, irq}, 32'h1);
      rdc(`SVP_ADDR_CH4, {16'd110, 16'h5a5a});
      upd(110, 1'b0);
      outs(3'b100);
      upd(110, 1'b0);
      outs(3'b110);
      rdc(`SVP_ADDR_STATUS, 32'h7);
      rdc(`SVP_ADDR_CNT_START, 32'h1);
      rdc(`SVP_ADDR_CNT_TRIP, 32'h1);
      // start is cleared, the trip flag stays but is masked
      wr(`SVP_ADDR_IRQ_STAT, 32'h1);
      // the clear lands on the edge that ends the write
      @(posedge hclk);
      chk({31'h0, irq}, 32'h0);
      rdc(`SVP_ADDR_IRQ_STAT, 32'h2);
      upd(102, 1'b0);
      outs(3'b110);
      upd(101, 1'b0);
      outs(3'b000);
      upd(110, 1'b0);
      block_in <= 1'b1;
      upd(110, 1'b0);
      outs(3'b001);
      upd(101, 1'b0);
      block_in <= 1'b0;
      wr(`SVP_ADDR_DELAY, 32'h0);
      upd(110, 1'b0);
      outs(3'b110);
      upd(101, 1'b0);
      wr(`SVP_ADDR_CTRL, 32'h1);
      upd(110, 1'b0);
      outs(3'b000);
      upd(110, 1'b1);
      outs(3'b110);
      upd(101, 1'b1);
      wr(`SVP_ADDR_CTRL, 32'h2);
      wr(`SVP_ADDR_USET, 32'd8000);
      wr(`SVP_ADDR_UBLK, 32'h0);
      wr(`SVP_ADDR_DELAY, 32'h2);
      upd(90, 1'b0);
      outs(3'b000);
      upd(70, 1'b0);
      outs(3'b100);
      upd(82, 1'b0);
      outs(3'b100);
      upd(83, 1'b0);
      outs(3'b000);
      repeat (3) upd(3, 1'b0);
      outs(3'b110);
      upd(90, 1'b0);
      wr(`SVP_ADDR_UBLK, 32'h1f4);
      repeat (4) upd(3, 1'b0);
      outs(3'b100);
      rdc(`SVP_ADDR_STATUS, 32'h13);
      upd(70, 1'b0);
      outs(3'b100);
      upd(90, 1'b0);
      repeat (3) upd(70, 1'b0);
      outs(3'b110);
      for (int k = 0; k < 4; k++) begin
         wr(`SVP_ADDR_CTRL, 32'h6 | (k << 3));
         repeat (3) @(posedge hclk);
         outs(ft[k]);
      end
      // updates stop: the stale flag and its event must appear
      wr(`SVP_ADDR_IRQ_STAT, 32'hf);
      repeat (45) @(posedge hclk);
      rdc(`SVP_ADDR_IRQ_STAT, 32'h8);
      rdc(`SVP_ADDR_STATUS, 32'h29);
      end_of_test();
   end

   // the sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge hclk);
      bad_count++;
      end_of_test();
   end
endmodule : svp_stage_tb
`default_nettype wire
